// >>> hdl/smtl_defines.svh
// constants for the serial memory transaction logic
`ifndef SMTL_DEFINES_SVH
`define SMTL_DEFINES_SVH
`define SMTL_OP_LATCH_SET 8'h06
`define SMTL_OP_READ 8'h03
`define SMTL_OP_WRITE 8'h02
`define SMTL_OP_QUICK_READ 8'h0B
`define SMTL_OP_SLEEP 8'hB9
`define SMTL_OP_IDENTITY 8'h9F
`define SMTL_OP_SERIAL 8'hC3
`define SMTL_ADDR_W 15
`define SMTL_ADDR_TOP 15'h7FFF
`define SMTL_QUARTER_BASE 15'h6000
`define SMTL_HALF_BASE 15'h4000
`define SMTL_SPAN_NONE 2'h0
`define SMTL_SPAN_QUARTER 2'h1
`define SMTL_SPAN_HALF 2'h2
`define SMTL_ID_CONT_LAST 4'h5
`define SMTL_ID_MANUF 4'h6
`define SMTL_ID_PROD0 4'h7
`define SMTL_ID_PROD1 4'h8
`define SMTL_SN_LAST 4'h7
`define SMTL_CRC_POLY 8'h07
`define SMTL_WAKE_US 400
`define SMTL_CLK_MHZ 250
`endif

// >>> hdl/smtl_pkg.sv
// types shared by the serial memory transaction logic
package smtl_pkg;
    typedef enum logic [3:0] {
        SMTL_IDLE = 4'b0000,
        SMTL_CMD = 4'b0001,
        SMTL_ADDR_HI = 4'b0010,
        SMTL_ADDR_LO = 4'b0011,
        SMTL_DUMMY = 4'b0100,
        SMTL_WRITE = 4'b0101,
        SMTL_READ = 4'b0110,
        SMTL_IDENT = 4'b0111,
        SMTL_SERIAL = 4'b1000,
        SMTL_IGNORE = 4'b1001,
        SMTL_SLEEP_PEND = 4'b1010,
        SMTL_SLEEP = 4'b1011,
        SMTL_WAKE = 4'b1100
    } smtl_state_t;
endpackage

// >>> hdl/smtl_core.sv
// serial slave transaction logic for a 32K x 8 byte memory
`timescale 1ns/1ps
`include "smtl_defines.svh"
module smtl_core
    import smtl_pkg::*;
#(
    parameter int WAKE_CYCLES = `SMTL_WAKE_US * `SMTL_CLK_MHZ,
    parameter logic [7:0] CONT_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] MANUF_CODE = 8'h3C, // arbitrary value
    parameter logic [2:0] FAMILY = 3'h3, // arbitrary value
    parameter logic [4:0] DENSITY = 5'h05, // arbitrary value
    parameter logic [1:0] SUBTYPE = 2'h1, // arbitrary value
    parameter logic [2:0] REVISION = 3'h2, // arbitrary value
    parameter logic [15:0] CUSTOMER_ID = 16'h1234, // arbitrary value
    parameter logic [39:0] UNIQUE_NUM = 40'hA5C3_1E96_4B // arbitrary value
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic shift_timing,
    input wire logic select_n,
    input wire logic serial_in,
    input wire logic pause_n,
    input wire logic write_protect_n,
    input wire logic [1:0] protect_span,
    input wire logic write_latch_clear,
    output logic serial_out,
    output logic serial_out_en,
    output logic write_latch_flag,
    output logic write_protect_taken_n,
    output logic asleep
);
    // =========================================================
    // read-only identity and serial number
    function automatic logic [7:0] crc8(input logic [55:0] data);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 55; i >= 0; i--) begin
            c = c[7] ^ data[i] ? ({c[6:0], 1'b0} ^ `SMTL_CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    localparam logic [63:0] SERIAL = {CUSTOMER_ID, UNIQUE_NUM,
        crc8({CUSTOMER_ID, UNIQUE_NUM})};
    localparam logic [7:0] PROD0 = {FAMILY, DENSITY};
    localparam logic [7:0] PROD1 = {SUBTYPE, REVISION, 3'h0};
    localparam logic [16:0] WAKE_LAST = 17'(WAKE_CYCLES - 1);

    function automatic logic [7:0] id_byte(input logic [3:0] i);
        if (i <= `SMTL_ID_CONT_LAST) return CONT_CODE;
        else if (i == `SMTL_ID_MANUF) return MANUF_CODE;
        else if (i == `SMTL_ID_PROD0) return PROD0;
        else if (i == `SMTL_ID_PROD1) return PROD1;
        else return 8'h00;
    endfunction

    function automatic logic [7:0] sn_byte(input logic [3:0] i);
        if (i <= `SMTL_SN_LAST) return SERIAL[8'(63 - 8 * i) -: 8];
        else return 8'h00;
    endfunction

    function automatic logic blocked(input logic [14:0] a, input logic [1:0] s);
        case (s)
            `SMTL_SPAN_NONE: return 1'b0;
            `SMTL_SPAN_QUARTER: return a >= `SMTL_QUARTER_BASE;
            `SMTL_SPAN_HALF: return a >= `SMTL_HALF_BASE;
            default: return 1'b1;
        endcase
    endfunction

    // =========================================================
    // pin synchronisers
    logic [4:0] sync1_q, sync2_q, prev_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= 5'h1E;
            sync2_q <= 5'h1E;
            prev_q <= 5'h1E;
        end else begin
            sync1_q <= {write_protect_n, pause_n, select_n, serial_in, shift_timing};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end
    logic sclk_s, sdi_s, sel_s, pause_s, wp_s;
    assign {wp_s, pause_s, sel_s, sdi_s, sclk_s} = sync2_q;
    wire sclk_rise = sclk_s & ~prev_q[0];
    wire sclk_fall = ~sclk_s & prev_q[0];
    wire sel_fall = ~sel_s & prev_q[2];
    wire sel_rise = sel_s & ~prev_q[2];

    // =========================================================
    // transaction engine
    logic [7:0] mem [0:`SMTL_ADDR_TOP];
    smtl_state_t state_q, state_d;
    logic [7:0] cmd_q, cmd_d, sh_q, sh_d, txb_q, txb_d;
    logic [2:0] bit_q, bit_d;
    logic [14:0] addr_q, addr_d;
    logic [16:0] wake_q, wake_d;
    logic hold_q, hold_d, wel_q, wel_d, wp_q, wp_d, out_q, out_d, en_q, en_d;
    logic mem_we;
    logic [7:0] byte_in;
    logic byte_done, shift_ok;
    logic [14:0] addr_full;

    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        sh_d = sh_q;
        txb_d = txb_q;
        bit_d = bit_q;
        addr_d = addr_q;
        wake_d = wake_q;
        hold_d = hold_q;
        wel_d = wel_q;
        wp_d = wp_q;
        out_d = out_q;
        mem_we = 1'b0;
        byte_in = {sh_q[6:0], sdi_s};
        addr_full = {addr_q[14:8], byte_in};
        // pause changes are only honoured while the link clock is low
        if (!sclk_s && state_q != SMTL_SLEEP && state_q != SMTL_WAKE) begin
            hold_d = ~pause_s;
        end
        shift_ok = sclk_rise && !hold_q && !sel_s;
        byte_done = shift_ok && bit_q == 3'h7;
        if (write_latch_clear) begin
            wel_d = 1'b0;
        end
        if (shift_ok && state_q != SMTL_SLEEP && state_q != SMTL_WAKE) begin
            sh_d = byte_in;
            bit_d = bit_q + 3'h1;
        end
        if (sclk_fall && !hold_q) begin
            out_d = txb_q[~bit_q];
        end
        case (state_q)
            SMTL_SLEEP: begin
                if (sel_fall) begin
                    state_d = SMTL_WAKE;
                    wake_d = WAKE_LAST;
                end
            end
            SMTL_WAKE: begin
                // commands that arrive while waking are simply lost
                wake_d = wake_q - 17'h1;
                if (wake_q == 17'h0) begin
                    state_d = sel_s ? SMTL_IDLE : SMTL_IGNORE;
                end
            end
            default: begin
                if (sel_fall) begin
                    state_d = SMTL_CMD;
                    bit_d = 3'h0;
                    hold_d = 1'b0;
                    wp_d = wp_s;
                end else if (sel_rise) begin
                    // partial bytes die here without touching the array
                    state_d = state_q == SMTL_SLEEP_PEND ? SMTL_SLEEP : SMTL_IDLE;
                    if (state_q == SMTL_WRITE) begin
                        wel_d = 1'b0;
                    end
                end else if (byte_done) begin
                    case (state_q)
                        SMTL_CMD: begin
                            cmd_d = byte_in;
                            addr_d = 15'h0;
                            case (byte_in)
                                `SMTL_OP_LATCH_SET: begin
                                    wel_d = 1'b1;
                                    state_d = SMTL_IGNORE;
                                end
                                `SMTL_OP_READ, `SMTL_OP_QUICK_READ: state_d = SMTL_ADDR_HI;
                                `SMTL_OP_WRITE: state_d = wel_q ? SMTL_ADDR_HI : SMTL_IGNORE;
                                `SMTL_OP_SLEEP: state_d = SMTL_SLEEP_PEND;
                                `SMTL_OP_IDENTITY: begin
                                    state_d = SMTL_IDENT;
                                    txb_d = id_byte(4'h0);
                                end
                                `SMTL_OP_SERIAL: begin
                                    state_d = SMTL_SERIAL;
                                    txb_d = sn_byte(4'h0);
                                end
                                default: state_d = SMTL_IGNORE;
                            endcase
                        end
                        SMTL_ADDR_HI: begin
                            addr_d = {byte_in[6:0], 8'h00};
                            state_d = SMTL_ADDR_LO;
                        end
                        SMTL_ADDR_LO: begin
                            addr_d = addr_full;
                            if (cmd_q == `SMTL_OP_QUICK_READ) begin
                                state_d = SMTL_DUMMY;
                            end else if (cmd_q == `SMTL_OP_READ) begin
                                state_d = SMTL_READ;
                                txb_d = mem[addr_full];
                                addr_d = addr_full + 15'h1;
                            end else begin
                                state_d = SMTL_WRITE;
                            end
                        end
                        SMTL_DUMMY, SMTL_READ: begin
                            state_d = SMTL_READ;
                            txb_d = mem[addr_q];
                            addr_d = addr_q + 15'h1;
                        end
                        SMTL_WRITE: begin
                            mem_we = !blocked(addr_q, protect_span);
                            addr_d = addr_q + 15'h1;
                        end
                        SMTL_IDENT: begin
                            addr_d = addr_q + 15'h1;
                            txb_d = id_byte(addr_d[3:0]);
                        end
                        SMTL_SERIAL: begin
                            addr_d = addr_q + 15'h1;
                            txb_d = sn_byte(addr_d[3:0]);
                        end
                        default: ;
                    endcase
                end
            end
        endcase
        en_d = (state_d == SMTL_READ || state_d == SMTL_IDENT || state_d == SMTL_SERIAL)
            && !hold_d && !sel_s;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= SMTL_IDLE;
            cmd_q <= 8'h00;
            sh_q <= 8'h00;
            txb_q <= 8'h00;
            bit_q <= 3'h0;
            addr_q <= 15'h0;
            wake_q <= 17'h0;
            hold_q <= 1'b0;
            wel_q <= 1'b0;
            wp_q <= 1'b1;
            out_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            sh_q <= sh_d;
            txb_q <= txb_d;
            bit_q <= bit_d;
            addr_q <= addr_d;
            wake_q <= wake_d;
            hold_q <= hold_d;
            wel_q <= wel_d;
            wp_q <= wp_d;
            out_q <= out_d;
            en_q <= en_d;
        end
    end

    // array has no reset; contents are nonvolatile in spirit
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[addr_q] <= byte_in;
        end
    end

    assign serial_out = out_q;
    assign serial_out_en = en_q;
    assign write_latch_flag = wel_q;
    assign write_protect_taken_n = wp_q;
    assign asleep = state_q == SMTL_SLEEP;

    // =========================================================
    // checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_sleep_armed;
        state_q == SMTL_SLEEP_PEND && sel_rise && !sel_fall;
    endsequence
    sequence s_wake_start;
        state_q == SMTL_SLEEP && sel_fall;
    endsequence
    a_addr_wrap: assert property (
        (state_q == SMTL_WRITE || state_q == SMTL_READ) && byte_done && !sel_rise
        && !sel_fall && addr_q == `SMTL_ADDR_TOP |=> addr_q == 15'h0)
        else $error("address did not wrap to zero");
    a_commit_byte: assert property (mem_we |->
        state_q == SMTL_WRITE && bit_q == 3'h7 && shift_ok)
        else $error("array written off a byte boundary");
    a_latch_gate: assert property (mem_we |-> wel_q)
        else $error("array written with latch clear");
    a_span_block: assert property (mem_we |-> !blocked(addr_q, protect_span))
        else $error("write reached a protected address");
    a_rise_float: assert property (sel_rise |=> !serial_out_en)
        else $error("output still driven after select rose");
    a_sleep_entry: assert property (s_sleep_armed |=> asleep ##1 !serial_out_en)
        else $error("sleep not entered after select rose");
    a_wake_bound: assert property (s_wake_start |=>
        state_q == SMTL_WAKE && !serial_out_en ##1 wake_q < 17'(WAKE_CYCLES))
        else $error("wake not started or counter out of range");
    a_sleep_float: assert property (state_q == SMTL_SLEEP || state_q == SMTL_WAKE
        |-> !serial_out_en)
        else $error("output driven while asleep or waking");
    a_wp_latched: assert property (!sel_fall |=> $stable(wp_q))
        else $error("protect level changed mid transaction");
    a_pause_freeze: assert property (hold_q && !sel_fall |=>
        $stable(bit_q) && $stable(out_q))
        else $error("activity during pause");
endmodule // smtl_core

// >>> sim/smtl_master.sv
// bus master model for the link side of the memory transaction logic
`timescale 1ns/1ps
module smtl_master (
    input wire logic core_clk,
    input wire logic serial_out,
    input wire logic serial_out_en,
    output logic shift_timing,
    output logic select_n,
    output logic serial_in,
    output logic pause_n
);
    // ========
    // link timing
    localparam int HALF = 20; // half of a 160 ns link period
    logic en_seen = 1'b0;
    initial begin
        shift_timing = 1'b0;
        select_n = 1'b1;
        serial_in = 1'b0;
        pause_n = 1'b1;
    end
    // ========
    // frame tasks
    // link clock stands still low whenever select moves
    task automatic sel(input logic v);
        @(posedge core_clk);
        select_n <= v;
        repeat (HALF) @(posedge core_clk);
    endtask
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nb; i++) begin
            serial_in <= tx[7 - i];
            repeat (HALF) @(posedge core_clk);
            // a floating line reads back inverted, so a late enable shows as bad data
            rx[7 - i] = serial_out_en ? serial_out : ~serial_out;
            en_seen = en_seen | serial_out_en;
            shift_timing <= 1'b1;
            repeat (HALF) @(posedge core_clk);
            shift_timing <= 1'b0;
        end
    endtask
    // pause moves only with the clock low; clock and data wiggle meanwhile
    task automatic hold_gap();
        repeat (4) @(posedge core_clk);
        pause_n <= 1'b0;
        repeat (HALF) @(posedge core_clk);
        repeat (2) begin
            serial_in <= ~serial_in;
            shift_timing <= 1'b1;
            repeat (HALF) @(posedge core_clk);
            shift_timing <= 1'b0;
            repeat (HALF) @(posedge core_clk);
        end
        pause_n <= 1'b1;
        repeat (HALF) @(posedge core_clk);
    endtask
endmodule // smtl_master

// >>> sim/smtl_core_tb.sv
// self-checking bench for the serial memory transaction logic
`timescale 1ns/1ps
`include "smtl_defines.svh"
module smtl_core_tb;
    // ========
    // setup
    localparam int WAKE = 400; // short wake, still longer than one link byte
    localparam logic [7:0] CONT = 8'h5A; // arbitrary value
    localparam logic [7:0] MANUF = 8'h3C; // arbitrary value
    localparam logic [2:0] FAM = 3'h3; // arbitrary value
    localparam logic [4:0] DENS = 5'h05; // arbitrary value
    localparam logic [1:0] SUB = 2'h1; // arbitrary value
    localparam logic [2:0] REV = 3'h2; // arbitrary value
    localparam logic [15:0] CUST = 16'h1234; // arbitrary value
    localparam logic [39:0] UNIQ = 40'hA5C3_1E96_4B; // arbitrary value
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic write_protect_n = 1'b1;
    logic [1:0] protect_span = 2'h0;
    logic write_latch_clear = 1'b0;
    logic shift_timing, select_n, serial_in, pause_n;
    logic serial_out, serial_out_en, write_latch_flag, write_protect_taken_n, asleep;
    int err_total = 0;
    int n_compared = 0;
    logic [7:0] mem_m [logic [14:0]];
    logic [7:0] q [$];
    logic [63:0] sn;
    wire logic [7:0] flags = {4'h0, write_latch_flag, write_protect_taken_n, asleep, serial_out_en};
    always #2 core_clk = ~core_clk;
    // identity constants stay at their defaults, which the bench expects
    smtl_core #(.WAKE_CYCLES(WAKE)) i_smtl_core (.core_clk(core_clk), .sys_rst(sys_rst),
        .shift_timing(shift_timing), .select_n(select_n), .serial_in(serial_in),
        .pause_n(pause_n), .write_protect_n(write_protect_n), .protect_span(protect_span),
        .write_latch_clear(write_latch_clear), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .write_latch_flag(write_latch_flag),
        .write_protect_taken_n(write_protect_taken_n), .asleep(asleep));
    smtl_master i_smtl_master (.core_clk(core_clk), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .shift_timing(shift_timing), .select_n(select_n),
        .serial_in(serial_in), .pause_n(pause_n));
    // ========
    // helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic done(input string t);
        $display("test %s finished, mismatches so far %0d", t, err_total);
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic prot(input logic [14:0] a, input logic [1:0] s);
        return s == 2'h3 || (s == `SMTL_SPAN_HALF && a >= `SMTL_HALF_BASE)
            || (s == `SMTL_SPAN_QUARTER && a >= `SMTL_QUARTER_BASE);
    endfunction
    // bitwise form, same result as the core's crc8
    function automatic logic [7:0] crc8(input logic [55:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 55; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? `SMTL_CRC_POLY : 8'h00);
        return c;
    endfunction
    task automatic wr(input logic [14:0] a, input logic [7:0] d[$], input logic arm,
        input int tail, input logic hold);
        logic [7:0] r;
        logic [14:0] p;
        p = a;
        if (arm) begin
            i_smtl_master.sel(1'b0);
            i_smtl_master.xfer(`SMTL_OP_LATCH_SET, 8, r);
            i_smtl_master.sel(1'b1);
            chk(flags, 8'h0C);
        end
        i_smtl_master.sel(1'b0);
        i_smtl_master.xfer(`SMTL_OP_WRITE, 8, r);
        i_smtl_master.xfer({1'b0, a[14:8]}, 8, r);
        i_smtl_master.xfer(a[7:0], 8, r);
        foreach (d[i]) begin
            i_smtl_master.xfer(d[i], 8, r);
            if (arm && !prot(p, protect_span)) mem_m[p] = d[i];
            p = p + 15'h1;
            if (hold && i == 0) i_smtl_master.hold_gap();
        end
        if (tail > 0) i_smtl_master.xfer(8'hFF, tail, r);
        i_smtl_master.sel(1'b1);
        chk(flags, 8'h04);
    endtask
    task automatic rd(input logic [7:0] op, input logic [14:0] a, input int n,
        output logic [7:0] o[$]);
        logic [7:0] r;
        o = {};
        i_smtl_master.sel(1'b0);
        i_smtl_master.xfer(op, 8, r);
        if (op == `SMTL_OP_READ || op == `SMTL_OP_QUICK_READ) begin
            i_smtl_master.xfer({1'b1, a[14:8]}, 8, r);
            i_smtl_master.xfer(a[7:0], 8, r);
        end
        if (op == `SMTL_OP_QUICK_READ) i_smtl_master.xfer(8'hC3, 8, r);
        for (int i = 0; i < n; i++) begin
            // data line keeps changing, it must be ignored
            i_smtl_master.xfer(8'hA5 ^ i[7:0], 8, r);
            o.push_back(r);
        end
        i_smtl_master.sel(1'b1);
        chk(flags, 8'h04);
    endtask
    task automatic rdc(input logic [7:0] op, input logic [14:0] a, input int n);
        logic [7:0] o[$];
        rd(op, a, n, o);
        foreach (o[i]) chk(o[i], mem_m[a + 15'(i)]);
    endtask
    // ========
    // tests
    initial begin
        // tests need about 65000 cycles
        repeat (90000) @(posedge core_clk);
        err_total++;
        close_out();
    end
    initial begin
        logic [7:0] r;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(flags, 8'h04);
        wr(15'h7FFE, {8'h11, 8'h22, 8'h33, 8'h44}, 1'b1, 0, 1'b0);
        rdc(`SMTL_OP_READ, 15'h7FFF, 3);
        rdc(`SMTL_OP_QUICK_READ, 15'h7FFE, 4);
        done("wrap");
        wr(15'h0100, {8'hA1, 8'hB2, 8'hC3}, 1'b1, 0, 1'b1);
        rdc(`SMTL_OP_READ, 15'h0100, 3);
        done("pause");
        i_smtl_master.sel(1'b0);
        i_smtl_master.xfer(`SMTL_OP_LATCH_SET, 8, r);
        i_smtl_master.sel(1'b1);
        write_latch_clear <= 1'b1;
        @(posedge core_clk);
        write_latch_clear <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(flags, 8'h04);
        wr(15'h0100, {8'h0F}, 1'b0, 0, 1'b0);
        rdc(`SMTL_OP_READ, 15'h0100, 1);
        wr(15'h0200, {8'h5C, 8'h6D}, 1'b1, 0, 1'b0);
        wr(15'h0200, {8'h7E}, 1'b1, 4, 1'b0);
        rdc(`SMTL_OP_READ, 15'h0200, 2);
        done("latch");
        wr(15'h3FFF, {8'h01, 8'h02}, 1'b1, 0, 1'b0);
        wr(15'h5FFF, {8'h03, 8'h04}, 1'b1, 0, 1'b0);
        for (int s = 0; s < 4; s++) begin
            protect_span <= s[1:0];
            wr(15'h3FFF, {8'h20 | s[7:0], 8'h30 | s[7:0]}, 1'b1, 0, 1'b0);
            wr(15'h5FFF, {8'h40 | s[7:0], 8'h50 | s[7:0]}, 1'b1, 0, 1'b0);
            rdc(`SMTL_OP_READ, 15'h3FFF, 2);
            rdc(`SMTL_OP_READ, 15'h5FFF, 2);
        end
        protect_span <= 2'h0;
        done("span");
        i_smtl_master.sel(1'b0);
        write_protect_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(flags, 8'h04);
        i_smtl_master.sel(1'b1);
        i_smtl_master.sel(1'b0);
        chk(flags, 8'h00);
        i_smtl_master.sel(1'b1);
        write_protect_n <= 1'b1;
        done("protect pin");
        rd(`SMTL_OP_IDENTITY, 15'h0, 9, q);
        foreach (q[i]) chk(q[i], i < 6 ? CONT : i == 6 ? MANUF
            : i == 7 ? {FAM, DENS} : {SUB, REV, 3'h0});
        rd(`SMTL_OP_SERIAL, 15'h0, 8, q);
        sn = {CUST, UNIQ, crc8({CUST, UNIQ})};
        foreach (q[i]) chk(q[i], sn[63 - 8 * i -: 8]);
        done("identity");
        i_smtl_master.sel(1'b0);
        i_smtl_master.xfer(`SMTL_OP_SLEEP, 7, r);
        i_smtl_master.sel(1'b1);
        chk(flags, 8'h04);
        i_smtl_master.sel(1'b0);
        i_smtl_master.xfer(`SMTL_OP_SLEEP, 8, r);
        chk(flags, 8'h04);
        i_smtl_master.sel(1'b1);
        chk(flags, 8'h06);
        i_smtl_master.xfer(`SMTL_OP_READ, 8, r);
        chk(flags, 8'h06);
        i_smtl_master.en_seen = 1'b0;
        i_smtl_master.sel(1'b0);
        // throwaway read starts the wake and outlasts it; a live read would drive the line
        for (int i = 0; i < 4; i++) i_smtl_master.xfer(i == 0 ? 8'h03 : 8'h01, 8, r);
        chk(flags, 8'h04);
        i_smtl_master.sel(1'b1);
        chk({7'h00, i_smtl_master.en_seen}, 8'h00);
        rdc(`SMTL_OP_READ, 15'h0100, 3);
        done("sleep");
        close_out();
    end
endmodule // smtl_core_tb
